// [pmrp_regs.svh]
// Register offsets, field positions, reset values and timing counts of the program word read port
`ifndef PMRP_REGS_SVH
`define PMRP_REGS_SVH

// Register offsets on the 9-bit special function register address
`define PMRP_DATA_LOW_OFFSET 9'h10c
`define PMRP_ADDR_LOW_OFFSET 9'h10d
`define PMRP_DATA_HIGH_OFFSET 9'h10e
`define PMRP_ADDR_HIGH_OFFSET 9'h10f
`define PMRP_CONTROL_OFFSET 9'h18c

// Field positions
`define PMRP_CTRL_TRIGGER_BIT 0
`define PMRP_CTRL_FIXED_ONE_BIT 7
`define PMRP_DATA_HIGH_MSB 5
`define PMRP_ADDR_HIGH_MSB 4
`define PMRP_ADDR_HIGH_USED_MSB 3

// Widths
`define PMRP_WORD_BITS 14
`define PMRP_ADDR_BITS 12
`define PMRP_IMPL_ADDR_BITS 11

// Reset values
`define PMRP_DATA_LOW_RESET 8'h00
`define PMRP_DATA_HIGH_RESET 6'h00
`define PMRP_ADDR_LOW_RESET 8'h00
`define PMRP_ADDR_HIGH_RESET 5'h00
`define PMRP_CONTROL_FIXED 8'h80
`define PMRP_UNMAPPED_READ 8'h00

// Timing: instruction cycles from trigger to the memory access slot
`define PMRP_READ_CYCLES 2

`endif

// [pmrp_pkg.sv]
// Types shared by the program word read port modules
`default_nettype none

package pmrp_pkg;

    // Sequencer states of a program word read
    typedef enum logic [1:0] {
        PMRP_IDLE,
        PMRP_WAIT,
        PMRP_ACCESS
    } pmrp_state_type;

    // One fetched program word
    typedef logic [13:0] pmrp_word_type;

    // One program memory address
    typedef logic [11:0] pmrp_addr_type;

endpackage : pmrp_pkg

`default_nettype wire

// [pmrp_fetch_unit.sv]
// Array access stage and data register pair of the program word read port
`default_nettype none
`include "pmrp_regs.svh"

module pmrp_fetch_unit
    import pmrp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Launch from the sequencer
    input wire logic launch_i,
    input wire pmrp_addr_type launch_addr_i,
    // Software writes to the data pair
    input wire logic wr_data_low_i,
    input wire logic wr_data_high_i,
    input wire logic [7:0] wdata_i,
    // Program memory array
    output logic array_rd_o,
    output pmrp_addr_type array_addr_o,
    input wire pmrp_word_type array_data_i,
    // Held word
    output pmrp_word_type word_o
);

    logic [7:0] data_low_reg;
    logic [5:0] data_high_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Array strobe and address

    // Strobe stands for exactly the access slot
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            array_rd_o <= 1'b0;
        end else begin
            array_rd_o <= launch_i;
        end
    end

    // Address is latched at launch and held until the next one
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            array_addr_o <= '0;
        end else if (launch_i) begin
            array_addr_o <= launch_addr_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data register pair

    // Low byte: completion of a read wins over a software write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_low_reg <= `PMRP_DATA_LOW_RESET;
        end else if (array_rd_o) begin
            data_low_reg <= array_data_i[7:0];
        end else if (wr_data_low_i) begin
            data_low_reg <= wdata_i;
        end
    end

    // High six bits, same priority
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            data_high_reg <= `PMRP_DATA_HIGH_RESET;
        end else if (array_rd_o) begin
            data_high_reg <= array_data_i[13:8];
        end else if (wr_data_high_i) begin
            data_high_reg <= wdata_i[`PMRP_DATA_HIGH_MSB:0];
        end
    end

    // Held word, one register per byte so each has a single writer
    assign word_o = {data_high_reg, data_low_reg};

endmodule : pmrp_fetch_unit

`default_nettype wire

// [pmrp_read_port.sv]
// Top of the program word read port: register file, read sequencer and slot signalling
`default_nettype none
`include "pmrp_regs.svh"

module pmrp_read_port
    import pmrp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register bus
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // CPU pipeline
    output logic nop_slot_o,
    // Program memory array
    output logic array_rd_o,
    output logic [11:0] array_addr_o,
    input wire logic [13:0] array_data_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address decode, used for every write and read select
    function automatic logic reg_hit(input logic [8:0] addr, input logic [8:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    // Builds the word address, dropping bits beyond the implemented array
    // eleven-bit address
    function automatic pmrp_addr_type word_address(input logic [4:0] high, input logic [7:0] low);
        pmrp_addr_type full;
        pmrp_addr_type mask;
        full = {high[`PMRP_ADDR_HIGH_USED_MSB:0], low};
        mask = pmrp_addr_type'((13'h0001 << `PMRP_IMPL_ADDR_BITS) - 13'h0001);
        word_address = full & mask;
    endfunction : word_address

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    pmrp_state_type state_reg;
    pmrp_state_type state_next;
    logic trigger_reg;
    logic [7:0] addr_low_reg;
    logic [4:0] addr_high_reg;
    logic [7:0] rdata_next;
    logic wr_data_low;
    logic wr_data_high;
    logic wr_addr_low;
    logic wr_addr_high;
    logic wr_control;
    logic start;
    logic launch;
    logic done;
    pmrp_word_type word;

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    // One select per register
    assign wr_data_low = wr_i && reg_hit(addr_i, `PMRP_DATA_LOW_OFFSET);
    assign wr_data_high = wr_i && reg_hit(addr_i, `PMRP_DATA_HIGH_OFFSET);
    assign wr_addr_low = wr_i && reg_hit(addr_i, `PMRP_ADDR_LOW_OFFSET);
    assign wr_addr_high = wr_i && reg_hit(addr_i, `PMRP_ADDR_HIGH_OFFSET);
    assign wr_control = wr_i && reg_hit(addr_i, `PMRP_CONTROL_OFFSET);

    assign start = wr_control && wdata_i[`PMRP_CTRL_TRIGGER_BIT] && (state_reg == PMRP_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Address register pair

    // Low address byte
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_low_reg <= `PMRP_ADDR_LOW_RESET;
        end else if (wr_addr_low) begin
            addr_low_reg <= wdata_i;
        end
    end

    // High address bits, including the two bits kept but never used
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_high_reg <= `PMRP_ADDR_HIGH_RESET;
        end else if (wr_addr_high) begin
            addr_high_reg <= wdata_i[`PMRP_ADDR_HIGH_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read sequencer

    // Next state: trigger, one executed instruction, then the access slot
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PMRP_IDLE: begin
                if (start) begin
                    state_next = PMRP_WAIT;
                end
            end
            PMRP_WAIT: begin
                state_next = PMRP_ACCESS;
            end
            PMRP_ACCESS: begin
                state_next = PMRP_IDLE;
            end
            default: begin
                state_next = PMRP_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= PMRP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign launch = (state_reg == PMRP_WAIT);
    assign done = (state_reg == PMRP_ACCESS);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trigger_reg <= 1'b0;
        end else if (start) begin
            trigger_reg <= 1'b1;
        end else if (done) begin
            trigger_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            nop_slot_o <= 1'b0;
        end else begin
            nop_slot_o <= launch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Array access and data pair

    pmrp_fetch_unit u_fetch (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .launch_i(launch),
        .launch_addr_i(word_address(addr_high_reg, addr_low_reg)),
        .wr_data_low_i(wr_data_low),
        .wr_data_high_i(wr_data_high),
        .wdata_i(wdata_i),
        .array_rd_o(array_rd_o),
        .array_addr_o(array_addr_o),
        .array_data_i(array_data_i),
        .word_o(word)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    // Selects the addressed register, unmapped reads give zero
    always_comb begin
        rdata_next = `PMRP_UNMAPPED_READ;
        if (reg_hit(addr_i, `PMRP_DATA_LOW_OFFSET)) begin
            rdata_next = word[7:0];
        end else if (reg_hit(addr_i, `PMRP_DATA_HIGH_OFFSET)) begin
            rdata_next = {2'h0, word[13:8]};
        end else if (reg_hit(addr_i, `PMRP_ADDR_LOW_OFFSET)) begin
            rdata_next = addr_low_reg;
        end else if (reg_hit(addr_i, `PMRP_ADDR_HIGH_OFFSET)) begin
            rdata_next = {3'h0, addr_high_reg};
        end else if (reg_hit(addr_i, `PMRP_CONTROL_OFFSET)) begin
            rdata_next = `PMRP_CONTROL_FIXED | {7'h00, trigger_reg};
        end
    end

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule : pmrp_read_port

`default_nettype wire

// [pmrp_read_port_monitor.sv]
// Concurrent checks on the ports of the program word read port
`default_nettype none

module pmrp_read_port_monitor
    import pmrp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register bus
    input wire logic [8:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Slot and array
    input wire logic nop_slot_o,
    input wire logic array_rd_o,
    input wire logic [11:0] array_addr_o,
    input wire logic [13:0] array_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_reg;
    logic [7:0] low_reg;
    logic [10:0] addr_reg;
    logic accept;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////
    // A trigger counts only while no read is pending
    assign accept = wr_i && addr_i == 9'h18c && wdata_i[0] && !busy_reg;

    // Pending read from accepted trigger to the access slot
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_reg <= 1'b0;
        end else if (accept) begin
            busy_reg <= 1'b1;
        end else if (array_rd_o) begin
            busy_reg <= 1'b0;
        end
    end

    // Shadow of data low and address pair; completion beats software writes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_reg <= 8'h00;
            addr_reg <= 11'h000;
        end else begin
            if (array_rd_o) begin
                low_reg <= array_data_i[7:0];
            end else if (wr_i && addr_i == 9'h10c) begin
                low_reg <= wdata_i;
            end
            if (wr_i && addr_i == 9'h10d) begin
                addr_reg[7:0] <= wdata_i;
            end
            if (wr_i && addr_i == 9'h10f) begin
                addr_reg[10:8] <= wdata_i[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    AST_SLOT_TIMING: assert property (accept |=> !array_rd_o ##1 array_rd_o ##1 !array_rd_o)
        else $error("access slot not two cycles after trigger");
    AST_NO_STRAY_SLOT: assert property (array_rd_o |-> $past(accept, 2))
        else $error("access slot without accepted trigger");
    AST_NOP_PAIRED: assert property (nop_slot_o == array_rd_o)
        else $error("no-op slot apart from access slot");
    AST_ADDR_SELECT: assert property (array_rd_o |-> array_addr_o == {1'b0, $past(addr_reg)})
        else $error("array address differs from address pair");
    AST_DATA_LOW_READ: assert property (rd_i && addr_i == 9'h10c |=> rdata_o == $past(low_reg))
        else $error("data low read differs from last word");
    AST_CTRL_FIXED: assert property (rd_i && addr_i == 9'h18c |=> rdata_o[7:1] == 7'h40)
        else $error("control fixed bits wrong");
    AST_HIGH_FIXED: assert property (rd_i && addr_i == 9'h10e |=> rdata_o[7:6] == 2'b00)
        else $error("data high upper bits not zero");
    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
endmodule : pmrp_read_port_monitor

`default_nettype wire

// [pmrp_array_model.sv]
// Behavioural program memory array facing the read port
`default_nettype none

module pmrp_array_model (
    // Access strobe and address from the port
    input wire logic array_rd_i,
    input wire logic [11:0] array_addr_i,
    // Word back to the port
    output logic [13:0] array_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] word;

    // Word derived from the address; inverted outside the slot so stale data never matches
    assign word = {array_addr_i[11:6] ^ array_addr_i[5:0] ^ 6'h2a, array_addr_i[7:0] ^ 8'h5a};
    assign array_data_o = array_rd_i ? word : ~word;
endmodule : pmrp_array_model

`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the program word read port
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, reset_n_i, wr_i, rd_i, nop_slot_o, array_rd_o;
    logic [8:0] addr_i;
    logic [7:0] wdata_i, rdata_o, got;
    logic [11:0] array_addr_o;
    logic [13:0] array_data_i, ew;
    logic [11:0] ea, slot_addr;
    int num_errors = 0;
    int compares = 0;
    int slots = 0;
    int nops = 0;

    pmrp_read_port uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nop_slot_o(nop_slot_o), .array_rd_o(array_rd_o),
        .array_addr_o(array_addr_o), .array_data_i(array_data_i));
    pmrp_array_model mem (.array_rd_i(array_rd_o), .array_addr_i(array_addr_o), .array_data_o(array_data_i));

    ////////////////////////////////////////////////////////////////
    // Clock, slot counter and watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (array_rd_o === 1'b1) begin
            slots++;
            slot_addr = array_addr_o;
        end
        if (nop_slot_o === 1'b1) nops++;
    end
    initial begin
        #100000;
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [8:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask : rd

    task do_reset;
        reset_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask : do_reset

    // Reset values of every register
    task test_reset;
        rd(9'h10c); check(got, 8'h00);
        rd(9'h10e); check(got, 8'h00);
        rd(9'h10d); check(got, 8'h00);
        rd(9'h10f); check(got, 8'h00);
        rd(9'h18c); check(got, 8'h80);
        $display("test_reset done");
    endtask : test_reset

    // Software access to the data pair, one unmapped place (9'h1ff) and a zero trigger write
    task test_data_rw;
        int s;
        s = slots;
        wr(9'h10c, 8'ha5);
        wr(9'h10e, 8'hff);
        wr(9'h1ff, 8'hff);
        wr(9'h18c, 8'hfe);
        rd(9'h10c); check(got, 8'ha5);
        rd(9'h10e); check(got, 8'h3f);
        rd(9'h1ff); check(got, 8'h00);
        rd(9'h18c); check(got, 8'h80);
        check(8'(slots - s), 8'h00);
        $display("test_data_rw done");
    endtask : test_data_rw

    // One word read; optionally a second trigger while busy, which must be ignored
    task test_word_read(input logic [7:0] ah, input logic [7:0] al, input logic again);
        int s;
        int n;
        s = slots;
        n = nops;
        ea = {1'b0, ah[2:0], al};
        ew = {ea[11:6] ^ ea[5:0] ^ 6'h2a, ea[7:0] ^ 8'h5a};
        wr(9'h10d, al);
        wr(9'h10f, ah);
        // no interrupts are raised around the trigger
        wr(9'h18c, 8'h01);
        if (again) begin
            wr(9'h18c, 8'h01);
        end else begin
            rd(9'h18c); check(got, 8'h81);
        end
        rd(9'h10c); check(got, ew[7:0]);
        rd(9'h10e); check(got, {2'b00, ew[13:8]});
        rd(9'h18c); check(got, 8'h80);
        rd(9'h10c); check(got, ew[7:0]);
        check(8'(slots - s), 8'h01);
        check(8'(nops - n), 8'h01);
        check(slot_addr[7:0], ea[7:0]);
        check({4'h0, slot_addr[11:8]}, {4'h0, ea[11:8]});
        $display("test_word_read done");
    endtask : test_word_read

    task conclude;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////
    // Main sequence, with a second reset in mid-run
    initial begin
        reset_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 9'h000;
        wdata_i = 8'h00;
        do_reset();
        test_reset();
        test_data_rw();
        test_word_read(8'h1d, 8'ha3, 1'b0);
        test_word_read(8'h07, 8'hff, 1'b1);
        do_reset();
        test_reset();
        conclude();
    end
endmodule : testbench

bind pmrp_read_port pmrp_read_port_monitor mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nop_slot_o(nop_slot_o),
    .array_rd_o(array_rd_o), .array_addr_o(array_addr_o), .array_data_i(array_data_i));

`default_nettype wire
